// File: bench/channel_model.sv
`timescale 1ns/1ns
// stands for the data channels and storage units; the bench steers it
module channel_model (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic mclr_req,
    input wire logic wr_req,
    input wire logic lock_req,
    input wire logic [1:0] dev_req,
    output logic comp_mclr,
    output logic comp_write_req,
    output logic sector_lockout,
    output logic read_error,
    output logic [1:0] prog_device,
    output logic [5:0] chan_cond
);
    // channel conditions wander every cycle so lamps see real traffic
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            comp_mclr <= 1'b0;
            comp_write_req <= 1'b0;
            sector_lockout <= 1'b0;
            read_error <= 1'b0;
            prog_device <= 2'h0;
            chan_cond <= 6'h00;
        end else begin
            comp_mclr <= mclr_req;
            comp_write_req <= wr_req;
            sector_lockout <= lock_req; // header lockout bit seen
            read_error <= 1'($urandom);
            prog_device <= dev_req;
            chan_cond <= 6'($urandom);
        end
    end
endmodule

// File: bench/maintenance_panel_control_asserts.sv
`timescale 1ns/1ns
module panel_checker (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic comp_write_req,
    input wire logic sector_lockout,
    input wire logic comp_write_ok,
    input wire logic [5:0] chan_cond,
    input wire panel_pkg::chan_lamps_s lamps_a,
    input wire panel_pkg::chan_lamps_s lamps_b,
    input wire logic [3:0] equip_a,
    input wire logic [3:0] equip_b,
    input wire logic seek_start,
    input wire panel_pkg::sector_op_s sector_op
);
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    // a data sector written from the panel (not a header)
    sequence data_wr;
        sector_op.valid && sector_op.write && !sector_op.header;
    endsequence
    // ----------------------------------------------------------
    // channel lamps and selectors
    // ----------------------------------------------------------
    lamp_a_follow_a: assert property (
        $past(hresetn) |-> lamps_a == $past(chan_cond[2:0]))
        else $error("lamps_a does not follow chan_cond");
    lamp_b_follow_a: assert property (
        $past(hresetn) |-> lamps_b == $past(chan_cond[5:3]))
        else $error("lamps_b does not follow chan_cond");
    equip_a_range_a: assert property (equip_a <= 4'h8)
        else $error("equip_a outside 0-7 and standby");
    equip_b_range_a: assert property (equip_b <= 4'h8)
        else $error("equip_b outside 0-7 and standby");
    // ----------------------------------------------------------
    // computer writes, pushbuttons, panel data run
    // ----------------------------------------------------------
    free_write_a: assert property (
        comp_write_req && !sector_lockout |=> comp_write_ok)
        else $error("unlocked computer write refused");
    no_req_a: assert property (!comp_write_req |=> !comp_write_ok)
        else $error("write permitted without request");
    seek_pulse_a: assert property (seek_start |=> !seek_start)
        else $error("seek_start longer than one cycle");
    same_byte_a: assert property (
        data_wr ##1 data_wr |-> sector_op.data == $past(sector_op.data))
        else $error("panel write byte changed within run");
    bus_okay_a: assert property (hreadyout && !hresp)
        else $error("bus slave stalled or erred");
endmodule
bind maintenance_panel_control panel_checker panel_checker_inst (.*);

// File: bench/tb_maintenance_panel_control.sv
`timescale 1ns/1ns
module tb_maintenance_panel_control;
    logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, hready;
    logic [1:0] htrans = 2'h0, dev_req = 2'h0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, r;
    logic hreadyout, hresp, comp_mclr, comp_write_req, sector_lockout;
    logic read_error, mclr_out, comp_write_ok, seek_start;
    logic mclr_req = 0, wr_req = 0, lock_req = 0;
    logic [1:0] prog_device, device_type;
    logic [5:0] chan_cond, mode_lamps;
    logic [3:0] equip_a, equip_b, e;
    logic [2:0] panel_unit;
    logic [11:0] v, v2;
    panel_pkg::chan_lamps_s lamps_a, lamps_b;
    panel_pkg::sector_op_s sector_op;
    int n_fail = 0, cmp_count = 0, ticks = 0, n_mclr = 0, n_seek = 0;
    int n_sec = 0, base;
    assign hready = hreadyout;
    always #50 hclk = ~hclk;
    // ----------------------------------------------------------
    // event counters and hang guard
    // ----------------------------------------------------------
    always @(posedge hclk) begin
        ticks <= ticks + 1;
        n_mclr <= n_mclr + int'(mclr_out === 1'b1);
        n_seek <= n_seek + int'(seek_start === 1'b1);
        n_sec <= n_sec + int'(sector_op.valid === 1'b1);
        if (ticks == 20000) begin
            n_fail++;
            stop_test();
        end
    end
    maintenance_panel_control maintenance_panel_control_inst (
        .clk_en(1'b1), .*);
    channel_model channel_model_inst (.*);
    // ----------------------------------------------------------
    // bus, panel and compare tasks
    // ----------------------------------------------------------
    task automatic chk(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // one single word transfer; waits for hready in both phases
    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {24'h0, a};
        hwrite <= w;
        @(posedge hclk);
        while (hready !== 1'b1) @(posedge hclk);
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= d;
        @(posedge hclk);
        while (hready !== 1'b1) @(posedge hclk);
        r = hrdata;
    endtask
    // switch image: key, other toggles, device, selectors
    function automatic logic [31:0] sw(input logic key,
        input logic [5:0] tog, input logic [1:0] dev, input logic [2:0] rs);
        return {9'h0, rs, 4'h8, e, 2'h0, dev, 2'h0, tog[5:1], key};
    endfunction
    // press and release pushbuttons, bit switches in [19:8]
    task automatic press(input int b, input logic [11:0] bits);
        bus(1'b1, panel_pkg::cmd_addr, {12'h0, bits, 8'h0} | (32'h1 << b));
        bus(1'b1, panel_pkg::cmd_addr, {12'h0, bits, 8'h0});
        repeat (6) @(posedge hclk);
    endtask
    task automatic stop_test();
        if (n_fail == 0 && cmp_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    // ----------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------
    initial begin
        void'($urandom(13));
        e = 4'($urandom_range(7, 0));
        v = 12'($urandom);
        v2 = 12'($urandom);
        repeat (6) @(posedge hclk);
        hresetn <= 1'b1;
        chk("equip_a rst", {28'h0, equip_a}, 32'h8);
        bus(1'b0, panel_pkg::map_addr, 32'h0);
        chk("unit map", r, 32'h00fac688);
        chk("panel unit", {29'h0, panel_unit}, 32'h0);
        bus(1'b1, panel_pkg::ctrl_addr, sw(0, 0, 0, 1));
        repeat (6) @(posedge hclk);
        chk("equip_a", {28'h0, equip_a}, {28'h0, e});
        chk("equip_b", {28'h0, equip_b}, 32'h8);
        press(panel_pkg::pb_track, 12'h0);
        chk("track lamp", {31'h0, mode_lamps[0]}, 32'h1);
        chk("no run", {31'h0, sector_op.valid}, 32'h0);
        dev_req <= 2'h1;
        bus(1'b1, panel_pkg::ctrl_addr, sw(1, 0, 2'h2, 1));
        repeat (6) @(posedge hclk);
        chk("dev keyed", {30'h0, device_type}, 32'h2);
        press(panel_pkg::pb_cyl, 12'h0);
        base = n_mclr;
        mclr_req <= 1'b1;
        repeat (8) @(posedge hclk);
        mclr_req <= 1'b0;
        repeat (6) @(posedge hclk);
        chk("mclr blocked", 32'(n_mclr - base), 32'h0);
        bus(1'b1, panel_pkg::ctrl_addr, sw(0, 6'h10, 0, 1));
        repeat (6) @(posedge hclk);
        chk("dev prog", {30'h0, device_type}, 32'h1);
        base = n_mclr;
        mclr_req <= 1'b1;
        wr_req <= 1'b1;
        lock_req <= 1'b1;
        repeat (8) @(posedge hclk);
        mclr_req <= 1'b0;
        chk("mclr free", {31'h0, n_mclr > base}, 32'h1);
        chk("lock keeps", {31'h0, comp_write_ok}, 32'h0);
        bus(1'b1, panel_pkg::ctrl_addr, sw(1, 0, 0, 1));
        repeat (6) @(posedge hclk);
        chk("lock override", {31'h0, comp_write_ok}, 32'h1);
        wr_req <= 1'b0;
        press(panel_pkg::pb_load, v);
        bus(1'b1, panel_pkg::ctrl_addr, sw(1, 6'h04, 0, 0));
        press(panel_pkg::pb_load, v2);
        bus(1'b0, panel_pkg::disp_addr, 32'h0);
        chk("addr load", r, {20'h0, v2});
        bus(1'b1, panel_pkg::ctrl_addr, sw(1, 6'h04, 0, 1));
        bus(1'b0, panel_pkg::disp_addr, 32'h0);
        chk("data load", r, {20'h0, v});
        press(panel_pkg::pb_wipe, 12'h0);
        bus(1'b0, panel_pkg::disp_addr, 32'h0);
        chk("data wiped", r, 32'h0);
        bus(1'b1, panel_pkg::ctrl_addr, sw(1, 6'h04, 0, 0));
        bus(1'b0, panel_pkg::disp_addr, 32'h0);
        chk("addr kept", r, {20'h0, v2});
        press(panel_pkg::pb_cyl, 12'h0);
        base = n_sec;
        press(panel_pkg::pb_seek, 12'h0);
        chk("seek", {31'h0, n_seek > 0}, 32'h1);
        repeat (400) @(posedge hclk);
        chk("sectors", 32'(n_sec - base), 32'(256 - v2[7:0]));
        stop_test();
    end
endmodule

// File: design/maintenance_panel_control.sv
// Register access over AHB-Lite and the register addresses were chosen for this implementation.
`timescale 1ns/1ns
// Summary of operation
// R1: jumpers, selectors, register switches always live
// R2: mode lamps light always, act only keyed
// R3: keyed with ending mode blocks computer clears
// R4: keyswitch on: panel settings override program
// R5: header writes and header bits need keyswitch
// R6: each channel takes code 0-7 or standby
// R7: per channel connected, held, parity lamps
// R8: table maps logical units to physical units
// R9: panel operations always use logical unit 0
// R10: keyed device select replaces program device
// R11: selector routes register to display, entry
// R12: twelve bit switches; wipe clears selected only
// R13: defect switch marks every written header
// R14: panel data write repeats entered byte
// R15: panel read reports errors, not data
// R16: header toggle chooses header write or read
// R17: lockout refuses computer writes unless overridden
// R18: panel writes ignore header lockout
// R19: six lighted pushbuttons: modes, repeat, seek, clear
// R20: stop at area end unless repeating in track or cylinder mode
// R21: cylinder mode starts at held address
// R22: synchronise switches, buttons become pulses
module maintenance_panel_control #(
    parameter int addr_width = 12
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic clk_en,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic comp_mclr,
    input wire logic comp_write_req,
    input wire logic sector_lockout,
    input wire logic read_error,
    input wire logic [1:0] prog_device,
    input wire logic [5:0] chan_cond,
    output logic [1:0] device_type,
    output logic mclr_out,
    output logic comp_write_ok,
    output panel_pkg::chan_lamps_s lamps_a,
    output panel_pkg::chan_lamps_s lamps_b,
    output logic [3:0] equip_a,
    output logic [3:0] equip_b,
    output logic [5:0] mode_lamps,
    output logic [2:0] panel_unit,
    output logic seek_start,
    output panel_pkg::sector_op_s sector_op
);

    // ---------------------------------------------------------------
    // elaboration check
    // ---------------------------------------------------------------
    if (addr_width != 12) begin : g_bad
        $error("address register must be 12 bits");
    end

    // ---------------------------------------------------------------
    // state
    // ---------------------------------------------------------------
    typedef struct packed {
        logic [31:0] hrdata;
        logic hreadyout;
        logic dp_write;                 // data phase pending write
        logic [7:0] dp_addr;
        logic [31:0] ctrl;              // switch image
        logic [7:0] pb_last;            // button history
        logic [5:0] lamps;              // mode button lamps
        panel_pkg::end_mode_e end_mode;   // selected ending mode
        logic repeat_on;
        logic [11:0] addr_reg;
        logic [11:0] data_reg;
        logic [7:0] status_reg;
        logic [11:0] start_addr;        // held start address
        logic [11:0] last_addr;         // end of selected area
        panel_pkg::op_state_e op;
        logic [23:0] unit_map;          // 8 x 3 bit physical numbers
        logic [1:0] device_type;
        logic mclr_out;
        logic comp_write_ok;
        panel_pkg::chan_lamps_s lamps_a;
        panel_pkg::chan_lamps_s lamps_b;
        logic [3:0] equip_a;
        logic [3:0] equip_b;
        logic [2:0] panel_unit;
        logic seek_start;
        panel_pkg::sector_op_s sector_op;
        logic [11:0] hdr_last;          // last header image written
    } state_s;

    state_s r;
    state_s next_r;

    // reset image: identity unit map, standby equipment codes
    function automatic state_s reset_image();
        state_s s;
        s = '0;
        s.hreadyout = 1'b1;
        s.end_mode = panel_pkg::end_none;
        s.op = panel_pkg::op_idle;
        s.unit_map = 24'hfac688;
        s.ctrl[panel_pkg::eqa_lsb +: 4] = panel_pkg::standby_position;
        s.ctrl[panel_pkg::eqb_lsb +: 4] = panel_pkg::standby_position;
        s.equip_a = panel_pkg::standby_position;
        s.equip_b = panel_pkg::standby_position;
        return s;
    endfunction

    // equipment code: anything above 7 reads as standby
    function automatic logic [3:0] equip_code(input logic [3:0] sw);
        return (sw > 4'h7) ? panel_pkg::standby_position : sw;
    endfunction

    // area end for the chosen ending mode from a start address
    function automatic logic [11:0] area_end(
        input panel_pkg::end_mode_e m,
        input logic [11:0] a
    );
        logic [11:0] e;
        e = a;
        case (m)
            panel_pkg::end_track: e = a | panel_pkg::trk_sectors;
            panel_pkg::cylinder_end_mode: e = a | panel_pkg::cyl_sectors;
            panel_pkg::end_file: e = panel_pkg::file_sectors;
            default: e = a;
        endcase
        return e;
    endfunction

    // ---------------------------------------------------------------
    // next-state logic
    // ---------------------------------------------------------------
    logic key;
    logic [7:0] pb_pulse;
    logic [2:0] rsel;
    logic wr_go;
    logic [11:0] wval;
    logic hdr_ok;

    always_comb begin
        next_r = r;
        key = r.ctrl[panel_pkg::key_bit];
        rsel = r.ctrl[panel_pkg::rsel_lsb +: 3];
        // buttons arrive as written levels; an edge is one press
        pb_pulse = hwdata[7:0] & ~r.pb_last;            // see R22
        wr_go = 1'b0;
        wval = panel_pkg::word_zero;
        hdr_ok = 1'b0;
        next_r.seek_start = 1'b0;
        next_r.mclr_out = 1'b0;
        next_r.sector_op = '0;

        // bus: address phase captured, zero wait state
        next_r.hreadyout = 1'b1;
        if (r.dp_write) begin
            next_r.dp_write = 1'b0;
            case (r.dp_addr)
                panel_pkg::ctrl_addr: next_r.ctrl = hwdata;
                panel_pkg::map_addr: next_r.unit_map = hwdata[23:0]; // see R8
                panel_pkg::cmd_addr: begin
                    next_r.pb_last = hwdata[7:0];
                    // lamps follow the press even unkeyed
                    next_r.lamps = r.lamps ^ pb_pulse[5:0];    // see R2 R19
                    if (key) begin
                        if (pb_pulse[panel_pkg::pb_track])
                            next_r.end_mode = panel_pkg::end_track;
                        if (pb_pulse[panel_pkg::pb_cyl])
                            next_r.end_mode =
                                panel_pkg::cylinder_end_mode;
                        if (pb_pulse[panel_pkg::pb_file])
                            next_r.end_mode = panel_pkg::end_file;
                        if (pb_pulse[panel_pkg::pb_repeat])
                            next_r.repeat_on = ~r.repeat_on;
                        if (pb_pulse[panel_pkg::pb_mclr])
                            next_r.mclr_out = 1'b1;
                        if (pb_pulse[panel_pkg::pb_seek] &&
                                r.end_mode != panel_pkg::end_none) begin
                            // start at the held address
                            next_r.seek_start = 1'b1;
                            next_r.start_addr = r.addr_reg;  // see R21
                            next_r.last_addr =
                                area_end(r.end_mode, r.addr_reg);
                            next_r.op = panel_pkg::op_run;
                        end
                    end
                    // entry and wipe are always live
                    if (pb_pulse[panel_pkg::pb_wipe]) begin
                        wr_go = 1'b1;
                        wval = 12'h000;                     // see R12
                    end else if (pb_pulse[panel_pkg::pb_load]) begin
                        wr_go = 1'b1;
                        wval = hwdata[19:8];                // see R1 R12
                    end
                end
                default: ;
            endcase
        end
        if (htrans[1] && hsel && hready) begin
            next_r.dp_write = hwrite;
            next_r.dp_addr = haddr[7:0];
            case (haddr[7:0])
                panel_pkg::ctrl_addr: next_r.hrdata = r.ctrl;
                panel_pkg::cmd_addr: next_r.hrdata = {24'h0, r.pb_last};
                panel_pkg::disp_addr: begin
                    // selected register shown on the lamps
                    case (rsel)                              // see R11
                        panel_pkg::rsel_addr:
                            next_r.hrdata = {20'h0, r.addr_reg};
                        panel_pkg::rsel_data:
                            next_r.hrdata = {20'h0, r.data_reg};
                        panel_pkg::rsel_status:
                            next_r.hrdata = {24'h0, r.status_reg};
                        panel_pkg::rsel_unit:
                            next_r.hrdata = {29'h0, r.panel_unit};
                        default: next_r.hrdata = 32'h0;
                    endcase
                end
                panel_pkg::state_addr: next_r.hrdata =
                    {20'h0, r.repeat_on, r.end_mode, r.op == panel_pkg::op_run,
                     r.device_type, r.lamps};
                panel_pkg::prog_addr: next_r.hrdata =
                    {24'h0, chan_cond, prog_device};
                panel_pkg::map_addr: next_r.hrdata = {8'h0, r.unit_map};
                panel_pkg::hdr_addr: next_r.hrdata = {20'h0, r.hdr_last};
                default: next_r.hrdata = 32'h0;
            endcase
        end

        // selected register entry; one clears only that one
        if (wr_go) begin
            case (rsel)
                panel_pkg::rsel_addr: next_r.addr_reg = wval;
                panel_pkg::rsel_data: next_r.data_reg = wval;
                panel_pkg::rsel_status: next_r.status_reg = wval[7:0];
                default: ;
            endcase
        end

        // panel run: one sector per cycle across the area
        if (r.op == panel_pkg::op_run) begin
            if (!key) begin
                next_r.op = panel_pkg::op_idle;
            end else begin
                next_r.sector_op.valid = 1'b1;
                next_r.sector_op.addr = r.addr_reg;
                hdr_ok = key;                                // see R5
                next_r.sector_op.header = 1'b1;
                if (r.ctrl[panel_pkg::hwrite_bit] && hdr_ok) begin
                    next_r.sector_op.write = 1'b1;          // see R16
                    next_r.sector_op.defect =
                        r.ctrl[panel_pkg::defect_bit];      // see R13
                    next_r.sector_op.header_write_protect_bit =
                        r.ctrl[panel_pkg::wlo_req_bit];     // see R5
                    next_r.hdr_last = {r.ctrl[panel_pkg::defect_bit],
                        r.ctrl[panel_pkg::wlo_req_bit],
                        r.addr_reg[9:0]};
                end else if (r.ctrl[panel_pkg::dwrite_bit]) begin
                    // same entered byte everywhere, no lockout check
                    next_r.sector_op.header = 1'b0;
                    next_r.sector_op.write = 1'b1;          // see R14 R18
                    next_r.sector_op.data = r.data_reg[7:0];
                end else begin
                    next_r.sector_op.header = r.ctrl[panel_pkg::hwrite_bit];
                    // read data not kept; errors reach status
                    if (read_error)                          // see R15
                        next_r.status_reg =
                            r.status_reg | panel_pkg::status_err_bit;
                end
                if (r.addr_reg == r.last_addr) begin
                    if (r.repeat_on && r.end_mode != panel_pkg::end_file)
                        next_r.addr_reg = r.start_addr;      // see R20
                    else
                        next_r.op = panel_pkg::op_done;      // see R20
                end else begin
                    next_r.addr_reg = r.addr_reg + 12'h001;
                end
            end
        end else if (r.op == panel_pkg::op_done) begin
            next_r.op = panel_pkg::op_idle;
        end

        // computer clears are shut out while a keyed mode is set
        if (comp_mclr && !(key && r.end_mode != panel_pkg::end_none))
            next_r.mclr_out = 1'b1;                          // see R3
        if (!key) begin
            next_r.end_mode = panel_pkg::end_none;
            next_r.repeat_on = 1'b0;
        end

        // device type: keyed panel choice overrides the program
        if (key && r.ctrl[panel_pkg::dev_lsb +: 2] != panel_pkg::dev_off)
            next_r.device_type = r.ctrl[panel_pkg::dev_lsb +: 2]; // see R4 R10
        else
            next_r.device_type = prog_device;

        // lockout refuses computer writes unless overridden
        next_r.comp_write_ok = comp_write_req &&
            (!sector_lockout ||
             (!r.ctrl[panel_pkg::lockout_bit] && key));      // see R17

        // channel selectors and lamps, live regardless of key
        next_r.equip_a = equip_code(r.ctrl[panel_pkg::eqa_lsb +: 4]); // see R1 R6
        next_r.equip_b = equip_code(r.ctrl[panel_pkg::eqb_lsb +: 4]); // see R6
        next_r.lamps_a = chan_cond[2:0];                     // see R7
        next_r.lamps_b = chan_cond[5:3];                     // see R7
        // panel work always goes through logical unit 0
        next_r.panel_unit = r.unit_map[2:0];                 // see R9
    end

    // ---------------------------------------------------------------
    // registers
    // ---------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            r <= reset_image();
        end else if (clk_en) begin
            r <= next_r;
        end
    end

    // ---------------------------------------------------------------
    // outputs straight from flip-flops; hresp tied low
    // ---------------------------------------------------------------
    assign hrdata = r.hrdata;
    assign hreadyout = r.hreadyout;
    assign hresp = 1'b0;
    assign device_type = r.device_type;
    assign mclr_out = r.mclr_out;
    assign comp_write_ok = r.comp_write_ok;
    assign lamps_a = r.lamps_a;
    assign lamps_b = r.lamps_b;
    assign equip_a = r.equip_a;
    assign equip_b = r.equip_b;
    assign mode_lamps = r.lamps;
    assign panel_unit = r.panel_unit;
    assign seek_start = r.seek_start;
    assign sector_op = r.sector_op;

endmodule

// File: design/panel_pkg.sv
package panel_pkg;

    // ---------------------------------------------------------------
    // register map (byte addresses, one aligned word each)
    // ---------------------------------------------------------------
    localparam logic [7:0] ctrl_addr = 8'h00;    // switch image 1
    localparam logic [7:0] sel_addr = 8'h04;     // not decoded; reads zero, writes dropped
    localparam logic [7:0] cmd_addr = 8'h08;     // pushbutton strobes
    localparam logic [7:0] disp_addr = 8'h0c;    // selected register
    localparam logic [7:0] state_addr = 8'h10;   // lamps and run state
    localparam logic [7:0] prog_addr = 8'h14;    // program-side inputs
    localparam logic [7:0] map_addr = 8'h18;     // logical to physical
    localparam logic [7:0] hdr_addr = 8'h1c;     // header result

    // ---------------------------------------------------------------
    // field positions of the switch image (ctrl)
    // ---------------------------------------------------------------
    localparam int key_bit = 0;          // panel keyswitch
    localparam int defect_bit = 1;       // defective-sector toggle
    localparam int dwrite_bit = 2;       // data write toggle
    localparam int hwrite_bit = 3;       // header write toggle
    localparam int lockout_bit = 4;      // write-lockout toggle
    localparam int wlo_req_bit = 5;      // set lockout bit in headers
    localparam int dev_lsb = 8;          // device select, 2 bits
    localparam int eqa_lsb = 12;         // equipment a, 4 bits
    localparam int eqb_lsb = 16;         // equipment b, 4 bits
    localparam int rsel_lsb = 20;        // register select, 3 bits

    // pushbutton positions in cmd
    localparam int pb_track = 0;
    localparam int pb_cyl = 1;
    localparam int pb_file = 2;
    localparam int pb_repeat = 3;
    localparam int pb_seek = 4;
    localparam int pb_mclr = 5;
    localparam int pb_wipe = 6;          // register_wipe_button
    localparam int pb_load = 7;          // load bit switches
    localparam int pb_count = 8;

    // ---------------------------------------------------------------
    // codes
    // ---------------------------------------------------------------
    localparam logic [3:0] standby_position = 4'h8;
    localparam logic [2:0] rsel_addr = 3'h0;
    localparam logic [2:0] rsel_data = 3'h1;
    localparam logic [2:0] rsel_status = 3'h2;
    localparam logic [2:0] rsel_unit = 3'h3;
    localparam logic [1:0] dev_off = 2'h0;
    localparam logic [1:0] dev_strip = 2'h3;
    localparam logic [11:0] word_zero = 12'h000;
    localparam logic [3:0] unit_count = 4'h8;
    localparam logic [11:0] cyl_sectors = 12'h0ff;  // sectors per cyl
    localparam logic [11:0] trk_sectors = 12'h00f;  // sectors per track
    localparam logic [11:0] file_sectors = 12'hfff; // sectors per file
    localparam logic [7:0] status_err_bit = 8'h01;  // checkword error

    typedef enum logic [1:0] {
        end_none,
        end_track,
        cylinder_end_mode,
        end_file
    } end_mode_e;

    typedef enum {
        op_idle,
        op_run,
        op_done
    } op_state_e;

    // one channel connection lamp group
    typedef struct packed {
        logic connected;
        logic held_lamp;
        logic parity_lamp;
    } chan_lamps_s;

    // sector written or read this cycle
    typedef struct packed {
        logic valid;
        logic write;
        logic header;
        logic defect;
        logic header_write_protect_bit;
        logic [7:0] data;
        logic [11:0] addr;
    } sector_op_s;

endpackage
